/* ims_port.sv */
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module ims_port
  import ims_pkg::*;
(
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SCL_DIR_IN,
  input wire logic SDA_DIR_IN,
  output ims_pin_type BUS_PINS,
  output logic PINS_OWNED
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  ims_sl_type sl_ff, nxt_sl;
  ims_ms_type ms_ff, nxt_ms;
  logic [1:0] sthi_ff, q_ff, nxt_q;
  logic [3:0] mode_ff, cnt_ff, nxt_cnt;
  logic [4:0] ctl2_trig_ff, nxt_trig;
  logic [6:0] brg_ff, nxt_brg;
  logic [7:0] sr_ff, nxt_sr, buf_ff, nxt_buf, addr_ff;
  logic da_ff, stop_ff, start_ff, rw_ff, ua_ff, bf_ff, col_ff, ov_ff;
  logic nxt_da, nxt_stop, nxt_start, nxt_rw, nxt_ua, nxt_bf, nxt_col, nxt_ov;
  logic en_ff, ckp_ff, general_call_enable_ff, ack_status_ff, ack_value_ff, pif_ff, nack_ff;
  logic nxt_ckp, nxt_ack_status, nxt_pif, nxt_nack, second_ff, nxt_second;
  logic hold_ff, nxt_hold, scl_q_ff, sda_q_ff, pready_ff;
  logic [1:0] mline;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire setup = PSEL & ~PENABLE;
  wire acc = PSEL & PENABLE & pready_ff;
  wire wr = acc & PWRITE;
  wire wr_st = wr & (PADDR == OFS_STATUS);
  wire wr_c1 = wr & (PADDR == OFS_CTRL1);
  wire wr_c2 = wr & (PADDR == OFS_CTRL2);
  wire wr_data = wr & (PADDR == OFS_DATA);
  wire wr_addr = wr & (PADDR == OFS_ADDR);
  wire wr_flag = wr & (PADDR == OFS_FLAG);
  wire rd_data = acc & ~PWRITE & (PADDR == OFS_DATA);
  wire hit = (PADDR == OFS_STATUS) | (PADDR == OFS_CTRL1) |
             (PADDR == OFS_CTRL2) | (PADDR == OFS_DATA) |
             (PADDR == OFS_ADDR) | (PADDR == OFS_FLAG);

  wire mode_mst = en_ff & (mode_ff == MODE_MST);
  wire mode_slv = en_ff & ((mode_ff == MODE_S7) | (mode_ff == MODE_S10) |
                  (mode_ff == MODE_S7_SS) | (mode_ff == MODE_S10_SS));
  wire i2c_mode = mode_mst | mode_slv | (mode_ff == MODE_FW_MST);
  wire ten = mode_ff[0];
  wire ssint = mode_ff[3];
  wire stretch_en = ctl2_trig_ff[C2_SEN];
  wire busy = (ms_ff != M_IDLE) | (|ctl2_trig_ff);
  wire tip = mode_mst & (ms_ff == M_TX);

  wire scl_rise = SCL_IN & ~scl_q_ff;
  wire scl_fall = ~SCL_IN & scl_q_ff;
  wire start_det = scl_q_ff & SCL_IN & sda_q_ff & ~SDA_IN;
  wire stop_det = scl_q_ff & SCL_IN & ~sda_q_ff & SDA_IN;
  wire full = bf_ff | ov_ff;
  wire amatch = second_ff ? (sr_ff == addr_ff) :
                ((sr_ff[7:1] == addr_ff[7:1]) |
                 (general_call_enable_ff & (sr_ff == GC_ADDR)));

  wire m_bit = ms_ff == M_ACK ? ack_value_ff :
               ms_ff == M_RX ? 1'b1 : (cnt_ff == BITS_BYTE) | sr_ff[7];
  wire stall = (ms_ff != M_IDLE) & ~mline[1] & ~SCL_IN;
  wire tick = (brg_ff == 7'h00) & ~stall;

  wire [7:0] status = {sthi_ff, da_ff, stop_ff, start_ff,
                       mode_mst ? tip : rw_ff, ua_ff, bf_ff};
  wire [7:0] ctl1 = {col_ff, ov_ff, en_ff, ckp_ff, mode_ff};
  wire [7:0] ctl2 = {general_call_enable_ff, ack_status_ff, ack_value_ff, ctl2_trig_ff};
  wire [7:0] rbyte = PADDR == OFS_STATUS ? status :
                     PADDR == OFS_CTRL1 ? ctl1 :
                     PADDR == OFS_CTRL2 ? ctl2 :
                     PADDR == OFS_DATA ? buf_ff :
                     PADDR == OFS_ADDR ? addr_ff : {7'h00, pif_ff};

  // slave holds scl low only at byte boundaries, when scl is already low; it pulls sda for acks and for zero bits it sends
  wire sl_scl_low = (~ckp_ff & ((sl_ff == SL_RX) | (sl_ff == SL_TX)) |
                    (sl_ff == SL_ADDR) & second_ff & ua_ff) &
                    (cnt_ff == 4'h0);
  wire sl_sda_low = ((sl_ff == SL_AACK) | (sl_ff == SL_RACK)) & ~nack_ff |
                    (sl_ff == SL_TX) & ~sr_ff[7];
  wire own = en_ff & i2c_mode;
  wire nxt_scl_oe = own & SCL_DIR_IN &
                    (mode_mst ? mline[1] : mode_slv & sl_scl_low);
  wire nxt_sda_oe = own & SDA_DIR_IN &
                    (mode_mst ? mline[0] : mode_slv & sl_sda_low);

  // {scl_low, sda_low} for each quarter of a master bit time
  function automatic logic [1:0] m_lines(ims_ms_type s, logic [1:0] q,
                                         logic b, logic h);
    logic edge_q;
    edge_q = (q == 2'd0) | (q == 2'd3);
    unique case (s)
      M_IDLE: m_lines = {h, 1'b0};
      M_START: m_lines = {q == 2'd3, q != 2'd0};
      M_RSTART: m_lines = {edge_q, q[1]};
      M_STOP: m_lines = {q == 2'd0, ~q[1]};
      M_TX, M_RX, M_ACK: m_lines = {edge_q, ~b};
    endcase
  endfunction

  assign mline = m_lines(ms_ff, q_ff, m_bit, hold_ff);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_sl = sl_ff;
    nxt_ms = ms_ff;
    nxt_q = q_ff;
    nxt_cnt = cnt_ff;
    nxt_brg = brg_ff;
    nxt_sr = sr_ff;
    nxt_buf = buf_ff;
    nxt_da = da_ff;
    nxt_stop = stop_ff;
    nxt_start = start_ff;
    nxt_rw = rw_ff;
    nxt_ua = ua_ff;
    nxt_bf = bf_ff;
    nxt_col = col_ff;
    nxt_ov = ov_ff;
    nxt_ckp = ckp_ff;
    nxt_ack_status = ack_status_ff;
    nxt_pif = pif_ff;
    nxt_nack = nack_ff;
    nxt_second = second_ff;
    nxt_hold = hold_ff;
    nxt_trig = ctl2_trig_ff;
    // software side first; hardware sets below win over clears
    if (wr_c1) begin
      nxt_col = PWDATA[C1_COL];
      nxt_ov = PWDATA[C1_OV];
      nxt_ckp = PWDATA[C1_CKP];
    end
    if (wr_c2) begin
      nxt_ack_status = PWDATA[C2_ACK_STATUS];
      if (!(mode_mst && busy))
        nxt_trig = PWDATA[4:0];
    end
    if (wr_addr)
      nxt_ua = 1'b0;
    if (rd_data)
      nxt_bf = 1'b0;
    if (wr_flag)
      nxt_pif = PWDATA[0];
    if (wr_data) begin
      if ((mode_mst && busy) ||
          (mode_slv && sl_ff == SL_TX && cnt_ff != 4'h0)) begin
        nxt_col = 1'b1;
      end else begin
        nxt_buf = PWDATA[7:0];
        nxt_sr = PWDATA[7:0];
        nxt_bf = 1'b1;
        if (mode_mst) begin
          nxt_ms = M_TX;
          nxt_cnt = 4'h0;
          nxt_q = 2'd0;
          nxt_brg = addr_ff[6:0];
        end
      end
    end
    // bus conditions
    if (start_det) begin
      nxt_start = 1'b1;
      nxt_stop = 1'b0;
    end else if (stop_det) begin
      nxt_stop = 1'b1;
      nxt_start = 1'b0;
    end
    // ---------------- slave ----------------
    if (!mode_slv) begin
      nxt_sl = SL_IDLE;
    end else if (start_det || stop_det) begin
      nxt_sl = start_det ? SL_ADDR : SL_IDLE;
      nxt_cnt = 4'h0;
      nxt_second = 1'b0;
      nxt_rw = 1'b0;
      if (ssint)
        nxt_pif = 1'b1;
    end else begin
      unique case (sl_ff)
        SL_IDLE, SL_WAIT: begin
        end
        SL_ADDR, SL_RX: begin
          if (scl_rise) begin
            nxt_sr = {sr_ff[6:0], SDA_IN};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == BITS_BYTE) begin
            nxt_cnt = 4'h0;
            if (sl_ff == SL_ADDR && !amatch) begin
              nxt_sl = SL_WAIT;
            end else begin
              nxt_nack = full;
              if (bf_ff)
                nxt_ov = 1'b1;
              if (!full) begin
                nxt_buf = sr_ff;
                nxt_bf = 1'b1;
              end
              if (sl_ff == SL_RX) begin
                nxt_da = 1'b1;
                nxt_sl = SL_RACK;
              end else begin
                nxt_da = 1'b0;
                nxt_sl = SL_AACK;
                if (!second_ff)
                  nxt_rw = sr_ff[0];
                if (ten && !sr_ff[0])
                  nxt_ua = 1'b1;
              end
            end
          end
        end
        SL_AACK, SL_RACK: begin
          if (scl_fall) begin
            nxt_pif = 1'b1;
            if (nack_ff) begin
              nxt_sl = SL_WAIT;
              nxt_rw = 1'b0;
            end else if (sl_ff == SL_AACK && ten && !second_ff && !rw_ff) begin
              nxt_sl = SL_ADDR;
              nxt_second = 1'b1;
            end else if (rw_ff) begin
              nxt_sl = SL_TX;
              nxt_ckp = 1'b0;
            end else begin
              nxt_sl = SL_RX;
              if (stretch_en && bf_ff)
                nxt_ckp = 1'b0;
            end
          end
        end
        SL_TX: begin
          if (scl_rise) begin
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == BITS_BYTE) begin
            nxt_sl = SL_TACK;
            nxt_bf = 1'b0;
          end else if (scl_fall && cnt_ff != 4'h0) begin
            nxt_sr = {sr_ff[6:0], 1'b1};
          end
        end
        SL_TACK: begin
          if (scl_rise) begin
            nxt_nack = SDA_IN;
          end else if (scl_fall) begin
            nxt_pif = 1'b1;
            nxt_cnt = 4'h0;
            nxt_da = 1'b1;
            nxt_sl = nack_ff ? SL_WAIT : SL_TX;
            nxt_rw = ~nack_ff & rw_ff;
            if (!nack_ff)
              nxt_ckp = 1'b0;
          end
        end
      endcase
    end
    // ---------------- master ----------------
    if (!mode_mst) begin
      nxt_ms = M_IDLE;
      nxt_hold = 1'b0;
    end else if (ms_ff == M_IDLE) begin
      if (|ctl2_trig_ff[4:1] || ctl2_trig_ff[C2_SEN]) begin
        nxt_q = 2'd0;
        nxt_cnt = 4'h0;
        nxt_brg = addr_ff[6:0];
        if (ctl2_trig_ff[C2_ACK_START])
          nxt_ms = M_ACK;
        else if (ctl2_trig_ff[C2_PEN])
          nxt_ms = M_STOP;
        else if (ctl2_trig_ff[C2_RESTART_START])
          nxt_ms = M_RSTART;
        else if (ctl2_trig_ff[C2_SEN])
          nxt_ms = M_START;
        else
          nxt_ms = M_RX;
      end
    end else if (tick) begin
      nxt_q = q_ff + 2'd1;
      nxt_brg = addr_ff[6:0];
      if (q_ff == 2'd2 && ms_ff == M_TX && cnt_ff == BITS_BYTE)
        nxt_ack_status = SDA_IN;
      if (q_ff == 2'd2 && ms_ff == M_RX)
        nxt_sr = {sr_ff[6:0], SDA_IN};
      if (q_ff == 2'd3) begin
        nxt_cnt = cnt_ff + 4'h1;
        unique case (ms_ff)
          M_START, M_RSTART, M_STOP, M_ACK: begin
            nxt_ms = M_IDLE;
            nxt_pif = 1'b1;
            nxt_hold = ms_ff != M_STOP;
            nxt_trig[C2_SEN] = ctl2_trig_ff[C2_SEN] & (ms_ff != M_START);
            nxt_trig[C2_RESTART_START] = ctl2_trig_ff[C2_RESTART_START] & (ms_ff != M_RSTART);
            nxt_trig[C2_PEN] = ctl2_trig_ff[C2_PEN] & (ms_ff != M_STOP);
            nxt_trig[C2_ACK_START] = ctl2_trig_ff[C2_ACK_START] & (ms_ff != M_ACK);
          end
          M_TX: begin
            nxt_sr = {sr_ff[6:0], 1'b1};
            if (cnt_ff == BITS_BYTE) begin
              nxt_ms = M_IDLE;
              nxt_pif = 1'b1;
              nxt_bf = 1'b0;
              nxt_hold = 1'b1;
            end
          end
          M_RX: begin
            if (cnt_ff == BITS_BYTE - 4'h1) begin
              nxt_ms = M_IDLE;
              nxt_pif = 1'b1;
              nxt_hold = 1'b1;
              nxt_trig[C2_RECEIVE_START] = 1'b0;
              if (bf_ff) begin
                nxt_ov = 1'b1;
              end else begin
                nxt_buf = sr_ff;
                nxt_bf = 1'b1;
              end
            end
          end
          M_IDLE: begin
          end
        endcase
      end
    end else if (brg_ff != 7'h00) begin
      nxt_brg = brg_ff - 7'h01;
    end
    // disabling the port drops both state machines, the bit and quarter counters, hold, ua and the start and stop flags
    if (!en_ff) begin
      nxt_start = 1'b0;
      nxt_stop = 1'b0;
      nxt_sl = SL_IDLE;
      nxt_ms = M_IDLE;
      nxt_cnt = 4'h0;
      nxt_q = 2'd0;
      nxt_hold = 1'b0;
      nxt_ua = 1'b0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      {sthi_ff, da_ff, stop_ff, start_ff, rw_ff, ua_ff, bf_ff} <= RST_REG;
      {col_ff, ov_ff, en_ff, ckp_ff, mode_ff} <= RST_REG;
      {general_call_enable_ff, ack_status_ff, ack_value_ff, ctl2_trig_ff} <= RST_REG;
      {buf_ff, sr_ff, addr_ff} <= {RST_REG, RST_REG, RST_REG};
      sl_ff <= SL_IDLE;
      ms_ff <= M_IDLE;
      {q_ff, cnt_ff, brg_ff} <= 13'h0000;
      {pif_ff, nack_ff, second_ff, hold_ff} <= 4'h0;
    end else begin
      if (wr_st)
        sthi_ff <= PWDATA[7:6];
      if (wr_c1)
        {en_ff, mode_ff} <= {PWDATA[C1_EN], PWDATA[3:0]};
      if (wr_c2)
        {general_call_enable_ff, ack_value_ff} <= {PWDATA[C2_GENERAL_CALL_ENABLE], PWDATA[C2_ACK_VALUE]};
      if (wr_addr)
        addr_ff <= PWDATA[7:0];
      {da_ff, stop_ff, start_ff, rw_ff, ua_ff, bf_ff} <=
        {nxt_da, nxt_stop, nxt_start, nxt_rw, nxt_ua, nxt_bf};
      {col_ff, ov_ff, ckp_ff} <= {nxt_col, nxt_ov, nxt_ckp};
      {ack_status_ff, ctl2_trig_ff} <= {nxt_ack_status, nxt_trig};
      {buf_ff, sr_ff} <= {nxt_buf, nxt_sr};
      sl_ff <= nxt_sl;
      ms_ff <= nxt_ms;
      {q_ff, cnt_ff, brg_ff} <= {nxt_q, nxt_cnt, nxt_brg};
      {pif_ff, nack_ff, second_ff, hold_ff} <=
        {nxt_pif, nxt_nack, nxt_second, nxt_hold};
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      {scl_q_ff, sda_q_ff} <= 2'b11;
      {pready_ff, PREADY, PSLVERR, PINS_OWNED} <= 4'h0;
      PRDATA <= 32'h0000_0000;
      BUS_PINS <= 4'h0;
    end else begin
      {scl_q_ff, sda_q_ff} <= {SCL_IN, SDA_IN};
      pready_ff <= setup;
      PREADY <= setup;
      PSLVERR <= setup & ~hit;
      if (setup)
        PRDATA <= {24'h000000, hit ? rbyte : 8'h00};
      PINS_OWNED <= own;
      BUS_PINS <= {1'b0, nxt_scl_oe, 1'b0, nxt_sda_oe};
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_stop_off;
    @(posedge MCLK) disable iff (!RSTN) !en_ff |=> !stop_ff;
  endproperty
  a_stop_off: assert property (p_stop_off)
    else $error("stop flag survived disable");
  property p_start_off;
    @(posedge MCLK) disable iff (!RSTN) !en_ff |=> !start_ff;
  endproperty
  a_start_off: assert property (p_start_off)
    else $error("start flag survived disable");
  property p_pins_off;
    @(posedge MCLK) disable iff (!RSTN)
      !en_ff |=> !BUS_PINS.scl_oe && !BUS_PINS.sda_oe && !PINS_OWNED;
  endproperty
  a_pins_off: assert property (p_pins_off)
    else $error("pins driven while disabled");
  property p_ov_sticky;
    @(posedge MCLK) disable iff (!RSTN) ov_ff && !wr_c1 |=> ov_ff;
  endproperty
  a_ov_sticky: assert property (p_ov_sticky)
    else $error("overflow cleared without software");
  property p_col_sticky;
    @(posedge MCLK) disable iff (!RSTN) col_ff && !wr_c1 |=> col_ff;
  endproperty
  a_col_sticky: assert property (p_col_sticky)
    else $error("collision cleared without software");
  property p_refuse;
    @(posedge MCLK) disable iff (!RSTN)
      mode_mst && busy && wr_c2 |=> (ctl2_trig_ff & ~$past(ctl2_trig_ff)) == 0;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("trigger accepted while busy");
  property p_ack_status;
    @(posedge MCLK) disable iff (!RSTN)
      mode_mst && ms_ff == M_TX && cnt_ff == BITS_BYTE && q_ff == 2'd2 &&
      tick |=> ack_status_ff == $past(SDA_IN);
  endproperty
  a_ack_status: assert property (p_ack_status)
    else $error("acknowledge status not captured");
  property p_ack_self_clear;
    @(posedge MCLK) disable iff (!RSTN)
      mode_mst && ms_ff == M_ACK && tick && q_ff == 2'd3
      |=> !ctl2_trig_ff[C2_ACK_START] && ms_ff == M_IDLE;
  endproperty
  a_ack_self_clear: assert property (p_ack_self_clear)
    else $error("ack trigger not cleared");
  property p_bf_read;
    @(posedge MCLK) disable iff (!RSTN)
      rd_data && sl_ff != SL_ADDR && sl_ff != SL_RX && ms_ff != M_RX
      |=> !bf_ff;
  endproperty
  a_bf_read: assert property (p_bf_read)
    else $error("buffer read left full flag set");
endmodule

/* ims_pkg.sv */
package ims_pkg;
  // ----------------------------------------
  // register map (APB byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_CTRL2 = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_ADDR = 8'h10;
  localparam logic [7:0] OFS_FLAG = 8'h14;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int ST_DA = 5;
  localparam int ST_STOP = 4;
  localparam int ST_START = 3;
  localparam int ST_RW = 2;
  localparam int ST_UA = 1;
  localparam int ST_BF = 0;
  localparam int C1_COL = 7;
  localparam int C1_OV = 6;
  localparam int C1_EN = 5;
  localparam int C1_CKP = 4;
  localparam int C2_GENERAL_CALL_ENABLE = 7;
  localparam int C2_ACK_STATUS = 6;
  localparam int C2_ACK_VALUE = 5;
  localparam int C2_ACK_START = 4;
  localparam int C2_RECEIVE_START = 3;
  localparam int C2_PEN = 2;
  localparam int C2_RESTART_START = 1;
  localparam int C2_SEN = 0;
  // ----------------------------------------
  // reset values, codes
  // ----------------------------------------
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [3:0] MODE_S10_SS = 4'hf;
  localparam logic [3:0] MODE_S7_SS = 4'he;
  localparam logic [3:0] MODE_FW_MST = 4'hb;
  localparam logic [3:0] MODE_MST = 4'h8;
  localparam logic [3:0] MODE_S10 = 4'h7;
  localparam logic [3:0] MODE_S7 = 4'h6;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [3:0] BITS_BYTE = 4'h8;

  typedef enum logic [2:0] {
    SL_IDLE, SL_WAIT, SL_ADDR, SL_AACK, SL_RX, SL_RACK, SL_TX, SL_TACK
  } ims_sl_type;

  typedef enum logic [2:0] {
    M_IDLE, M_START, M_RSTART, M_STOP, M_TX, M_RX, M_ACK
  } ims_ms_type;

  typedef struct packed {
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
  } ims_pin_type;
endpackage

/* ims_far_master.sv */
`timescale 1ns/1ps
// ----------------------------------------
// far-side bus master, open-drain pulls only
// ----------------------------------------
module ims_far_master (
  input wire logic mclk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic gap();
    repeat (8) @(posedge mclk);
  endtask
  // rise only once the slave lets go, so stretching is honoured
  task automatic rise();
    scl_low <= 1'b0;
    @(posedge mclk);
    while (!scl) @(posedge mclk);
    gap();
  endtask
  task automatic start();
    sda_low <= 1'b1;
    gap();
    scl_low <= 1'b1;
    gap();
  endtask
  // msb first, data changes only while clock is low
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= ~b[i];
      gap();
      rise();
      scl_low <= 1'b1;
      gap();
    end
    sda_low <= 1'b0;
    gap();
    rise();
    ack = sda;
    scl_low <= 1'b1;
    gap();
  endtask
  // master-receiver: sample while clock is high, then answer the byte
  task automatic recv(input logic nak, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= 1'b0;
      gap();
      rise();
      b[i] = sda;
      scl_low <= 1'b1;
      gap();
    end
    sda_low <= ~nak;
    gap();
    rise();
    scl_low <= 1'b1;
    gap();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    gap();
    rise();
    sda_low <= 1'b0;
    gap();
  endtask
endmodule

/* tb_ims_port.sv */
`timescale 1ns/1ps
module tb_ims_port
  import ims_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic owned;
  logic scl_low;
  logic sda_low;
  logic ack;
  logic err;
  logic [31:0] q;
  logic [7:0] rx;
  ims_pin_type pins;
  // pull-ups: a line is low only while someone pulls it
  wire logic scl = ~(scl_low | pins.scl_oe);
  wire logic sda = ~(sda_low | pins.sda_oe);
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [16:0] rows [10] = '{
    {1'b0, OFS_STATUS, 8'h00},
    {1'b0, OFS_CTRL1, 8'h00},
    {1'b0, OFS_CTRL2, 8'h00},
    {1'b1, OFS_STATUS, 8'hff},
    {1'b0, OFS_STATUS, 8'hc0},
    {1'b1, OFS_STATUS, 8'h00},
    {1'b1, OFS_ADDR, 8'hff},
    {1'b0, OFS_ADDR, 8'hff},
    {1'b1, OFS_CTRL1, 8'h36},
    {1'b0, OFS_CTRL1, 8'h36}
  };
  logic [3:0] modes [7] = '{4'hf, 4'he, 4'hb, 4'h8, 4'h7, 4'h0, 4'h6};

  always #25 mclk = ~mclk;

  ims_port DUT (
    .MCLK(mclk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SCL_IN(scl), .SDA_IN(sda),
    .SCL_DIR_IN(1'b1), .SDA_DIR_IN(1'b1), .BUS_PINS(pins),
    .PINS_OWNED(owned)
  );
  ims_far_master far (
    .mclk(mclk), .scl(scl), .sda(sda), .scl_low(scl_low),
    .sda_low(sda_low)
  );
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hff);
    apb(1'b0, a, 8'h00);
    chk(q[7:0] & m, e);
  endtask
  // bounded wait on a register field; the limit is far above need
  task automatic poll(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, a, 8'h00);
      if ((q[7:0] & m) === e) break;
    end
    chk(q[7:0] & m, e);
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      close_out();
    end
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    chk({7'h00, owned}, 8'h00);
    foreach (rows[i]) begin
      if (rows[i][16]) apb(1'b1, rows[i][15:8], rows[i][7:0]);
      else rd(rows[i][15:8], rows[i][7:0]);
    end
    rd(8'h18, 8'h00);
    chk({7'h00, err}, 8'h01);
    foreach (modes[i]) begin
      apb(1'b1, OFS_CTRL1, {4'h3, modes[i]});
      repeat (2) @(posedge mclk);
      chk({7'h00, owned}, {7'h00, modes[i] != 4'h0});
    end
    far.start();
    rd(OFS_STATUS, 8'h08);
    far.send(8'hfe, ack);
    chk({7'h00, ack}, 8'h00);
    rd(OFS_STATUS, 8'h09);
    rd(OFS_FLAG, 8'h01, 8'h01);
    rd(OFS_DATA, 8'hfe);
    rd(OFS_STATUS, 8'h00, 8'h01);
    far.send(8'h5a, ack);
    chk({7'h00, ack}, 8'h00);
    rd(OFS_STATUS, 8'h21, 8'h21);
    far.send(8'h33, ack);
    chk({7'h00, ack}, 8'h01);
    rd(OFS_CTRL1, 8'h76);
    rd(OFS_DATA, 8'h5a);
    far.stop();
    rd(OFS_STATUS, 8'h10, 8'h19);
    apb(1'b1, OFS_CTRL1, 8'h36);
    rd(OFS_CTRL1, 8'h36);
    for (int g = 0; g < 2; g++) begin
      apb(1'b1, OFS_CTRL2, {g[0], 7'h00});
      far.start();
      far.send(8'h00, ack);
      far.stop();
      chk({7'h00, ack}, {7'h00, ~g[0]});
    end
    rd(OFS_DATA, 8'h00);
    far.start();
    far.send(8'hff, ack);
    chk({7'h00, ack}, 8'h00);
    rd(OFS_STATUS, 8'h05, 8'h05);
    rd(OFS_CTRL1, 8'h26);
    chk({7'h00, pins.scl_oe}, 8'h01);
    apb(1'b1, OFS_DATA, 8'hc3);
    apb(1'b1, OFS_CTRL1, 8'h36);
    far.recv(1'b1, rx);
    chk(rx, 8'hc3);
    rd(OFS_STATUS, 8'h00, 8'h01);
    far.stop();
    apb(1'b1, OFS_CTRL1, 8'h06);
    rd(OFS_STATUS, 8'h00, 8'h18);
    chk({7'h00, owned}, 8'h00);
    apb(1'b1, OFS_ADDR, 8'h01);
    apb(1'b1, OFS_CTRL1, 8'h28);
    apb(1'b1, OFS_CTRL2, 8'h01);
    poll(OFS_CTRL2, 8'h01, 8'h00);
    rd(OFS_STATUS, 8'h08, 8'h18);
    apb(1'b1, OFS_DATA, 8'ha5);
    rd(OFS_STATUS, 8'h04, 8'h04);
    apb(1'b1, OFS_CTRL2, 8'h04);
    rd(OFS_CTRL2, 8'h00, 8'h04);
    apb(1'b1, OFS_DATA, 8'h11);
    rd(OFS_CTRL1, 8'h80, 8'h80);
    poll(OFS_STATUS, 8'h04, 8'h00);
    rd(OFS_CTRL2, 8'h40, 8'h40);
    apb(1'b1, OFS_CTRL2, 8'h08);
    poll(OFS_CTRL2, 8'h08, 8'h00);
    rd(OFS_DATA, 8'hff);
    apb(1'b1, OFS_CTRL2, 8'h30);
    poll(OFS_CTRL2, 8'h10, 8'h00);
    apb(1'b1, OFS_CTRL2, 8'h02);
    poll(OFS_CTRL2, 8'h02, 8'h00);
    apb(1'b1, OFS_CTRL2, 8'h04);
    poll(OFS_CTRL2, 8'h04, 8'h00);
    rd(OFS_STATUS, 8'h10, 8'h18);
    close_out();
  end
endmodule
